/* hw/sfp_top.sv */
// FIFO serial port: APB registers, FIFOs, master and slave shift engine.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module sfp_top
   import sfp_pkg::*;
#(
   parameter int ADDR_W = 18
)
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic RSTN,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Serial link.
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE,
   input wire logic SS_I,
   output logic SS_O,
   output logic SS_OE,
   input wire logic SIN_I,
   output logic SOUT_O,
   output logic SOUT_OE,
   // Interrupt request pulse.
   output logic IRQ
);

   logic [31:0] ctrl;
   logic [31:0] timing;
   logic [15:0] tx_mem [FIFO_DEPTH];
   logic [15:0] rx_mem [FIFO_DEPTH];
   logic [1:0] tx_wp, tx_rp, rx_wp, rx_rp;
   logic [2:0] tx_cnt, rx_cnt;
   logic [15:0] tx_hold;
   logic [5:0] flags;
   logic wof;
   sfp_state_t state, next_state;
   logic [19:0] tmr, next_tmr;
   logic [4:0] ecnt, next_ecnt, bcnt;
   logic next_sck, next_ss;
   logic [15:0] tx_sh, rx_sh;
   logic sck_prev, ss_prev, sl_busy, push_pend;
   logic do_load, do_drive, do_sample, unit_end, fin_set, load_drive;

   wire en = ctrl[CTRL_ENABLE];
   wire mst = ctrl[CTRL_MASTER];
   wire cpol = ctrl[CTRL_CPOL];
   wire cpha = ctrl[CTRL_CPHA];
   wire lsb = ctrl[CTRL_LSB_FIRST];
   wire wsz = ctrl[CTRL_WORD];
   wire fclr = ctrl[CTRL_FIFO_CLEAR];
   wire [2:0] tx_thr = ctrl[CTRL_TX_THR_LSB +: 3];
   wire [2:0] rx_thr = ctrl[CTRL_RX_THR_LSB +: 3];
   wire [9:0] div = timing[TIM_DIV_LSB +: 10];
   wire [9:0] hdiv = (div == 10'h000) ? 10'h001 : div;
   wire [1:0] lead = sfp_halves(timing[TIM_LEAD_LSB +: 2]);
   wire [1:0] lag = sfp_halves(timing[TIM_LAG_LSB +: 2]);
   wire [7:0] gap = timing[TIM_GAP_LSB +: 8];
   wire tx_full = (tx_cnt == 3'(FIFO_DEPTH));
   wire rx_full = (rx_cnt == 3'(FIFO_DEPTH));
   wire tx_empty = (tx_cnt == 3'h0);
   wire rx_empty = (rx_cnt == 3'h0);

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode. One wait state: PREADY rises in the second access cycle.

   wire acc = PSEL & PENABLE & PREADY;
   wire wr_ev = acc & PWRITE;
   wire rd_ev = acc & ~PWRITE;
   wire sel_ctrl = (PADDR == ADDR_W'({IDX_CTRL, 2'b00}));
   wire sel_tim = (PADDR == ADDR_W'({IDX_TIMING, 2'b00}));
   wire sel_stat = (PADDR == ADDR_W'({IDX_STATUS, 2'b00}));
   wire sel_clr = (PADDR == ADDR_W'({IDX_FLAG_CLEAR, 2'b00}));
   wire sel_fill = (PADDR == ADDR_W'({IDX_FILL, 2'b00}));
   wire sel_tx = (PADDR == ADDR_W'({IDX_TX_DATA, 2'b00}));
   wire sel_rx = (PADDR == ADDR_W'({IDX_RX_DATA, 2'b00}));
   wire hit = sel_ctrl | sel_tim | sel_stat | sel_clr | sel_fill | sel_tx | sel_rx;

   wire [15:0] clr = (wr_ev & sel_clr) ? PWDATA[15:0] : 16'h0000;
   wire [15:0] wdata = wsz ? PWDATA[15:0] : {8'h00, PWDATA[7:0]};
   wire tx_push = wr_ev & sel_tx & ~tx_full & ~fclr;
   wire wof_set = wr_ev & sel_tx & tx_full;
   wire rx_pop = rd_ev & sel_rx & ~rx_empty & ~fclr;
   wire tx_pop = do_load & ~tx_empty & ~fclr;
   wire rx_push = push_pend & ~rx_full & ~fclr;
   wire orf_set = push_pend & rx_full;
   wire mdf_set = en & mst & SS_O & ~SS_I;
   wire [2:0] tx_after = tx_cnt - 3'h1;
   wire [2:0] rx_after = rx_cnt + 3'h1;
   wire [15:0] load_val = tx_empty ? IDLE_FILL : tx_mem[tx_rp];
   wire [15:0] rx_val = wsz ? rx_sh : (lsb ? {8'h00, rx_sh[15:8]} : {8'h00, rx_sh[7:0]});

   wire [15:0] stat_word = {3'h0, rx_empty, rx_full, tx_empty, tx_full, wof, 2'h0, flags};
   wire [15:0] fill_word = {5'h00, rx_cnt, 5'h00, tx_cnt};

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end
      else if (PSEL && PENABLE && !PREADY)
      begin
         PREADY <= 1'b1;
         PSLVERR <= ~hit;
         if (sel_ctrl)
            PRDATA <= ctrl;
         else if (sel_tim)
            PRDATA <= timing;
         else if (sel_stat)
            PRDATA <= {16'h0000, stat_word};
         else if (sel_fill)
            PRDATA <= {16'h0000, fill_word};
         else if (sel_tx)
            PRDATA <= {16'h0000, tx_hold};
         else if (sel_rx)
            PRDATA <= {16'h0000, rx_mem[rx_rp]};
         else
            PRDATA <= 32'h0000_0000;
      end
      else
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
   end

   // A mode fault drops the port back to a disabled slave.
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ctrl <= CTRL_RESET;
         timing <= TIMING_RESET;
         tx_hold <= 16'h0000;
      end
      else
      begin
         if (wr_ev && sel_ctrl)
            ctrl <= PWDATA;
         if (mdf_set)
         begin
            ctrl[CTRL_MASTER] <= 1'b0;
            ctrl[CTRL_ENABLE] <= 1'b0;
         end
         if (wr_ev && sel_tim)
            timing <= PWDATA;
         if (wr_ev && sel_tx)
            tx_hold <= wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // FIFOs. Entries are 16 bits, so bytes and words share the same depth.

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         tx_wp <= 2'h0;
         tx_rp <= 2'h0;
         tx_cnt <= 3'h0;
         rx_wp <= 2'h0;
         rx_rp <= 2'h0;
         rx_cnt <= 3'h0;
      end
      else if (fclr)
      begin
         tx_wp <= 2'h0;
         tx_rp <= 2'h0;
         tx_cnt <= 3'h0;
         rx_wp <= 2'h0;
         rx_rp <= 2'h0;
         rx_cnt <= 3'h0;
      end
      else
      begin
         if (tx_push)
            tx_wp <= tx_wp + 2'h1;
         if (tx_pop)
            tx_rp <= tx_rp + 2'h1;
         tx_cnt <= tx_cnt + 3'(tx_push) - 3'(tx_pop);
         if (rx_push)
            rx_wp <= rx_wp + 2'h1;
         if (rx_pop)
            rx_rp <= rx_rp + 2'h1;
         rx_cnt <= rx_cnt + 3'(rx_push) - 3'(rx_pop);
      end
   end

   always_ff @(posedge CLK)
   begin
      if (tx_push)
         tx_mem[tx_wp] <= wdata;
      if (rx_push)
         rx_mem[rx_wp] <= rx_val;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status flags. A hardware set in the same cycle as a clear wins.

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         flags <= 6'h00;
         wof <= 1'b0;
         IRQ <= 1'b0;
      end
      else
      begin
         flags[FLG_TX_THR] <= (flags[FLG_TX_THR] & ~clr[FLG_TX_THR])
            | (tx_pop & (tx_after == tx_thr));
         flags[FLG_RX_THR] <= (flags[FLG_RX_THR] & ~clr[FLG_RX_THR])
            | (rx_push & (rx_thr != 3'h0) & (rx_after >= rx_thr));
         flags[FLG_DONE] <= (flags[FLG_DONE] & ~clr[FLG_DONE]) | fin_set;
         flags[FLG_OVERRUN] <= (flags[FLG_OVERRUN] & ~clr[FLG_OVERRUN]) | orf_set;
         flags[FLG_MODE_FAULT] <= (flags[FLG_MODE_FAULT] & ~clr[FLG_MODE_FAULT])
            | mdf_set;
         flags[FLG_UNIT_DONE] <= (flags[FLG_UNIT_DONE] & ~clr[FLG_UNIT_DONE])
            | push_pend;
         wof <= (wof & ~clr[FLG_WRITE_OVF]) | wof_set;
         IRQ <= (tx_pop & (tx_after == tx_thr))
            | (rx_push & (rx_thr != 3'h0) & (rx_after >= rx_thr))
            | fin_set | orf_set | mdf_set
            | (clr[CLR_REREQUEST] & (|flags[4:0]));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: master timing and slave edge detection.

   wire s_on = en & ~mst;
   wire s_act = s_on & ~SS_I;
   wire ss_fall = s_on & ss_prev & ~SS_I;
   wire lead_e = s_act & (SCK_I != cpol) & (sck_prev == cpol);
   wire trail_e = s_act & (SCK_I == cpol) & (sck_prev != cpol);
   wire [4:0] last_edge = wsz ? LAST_EDGE_WORD : LAST_EDGE_BYTE;
   wire [4:0] last_bit = wsz ? LAST_BIT_WORD : LAST_BIT_BYTE;
   wire [19:0] half_t = 20'(hdiv) - 20'h1;
   wire [19:0] lead_t = 20'(lead) * 20'(hdiv) - 20'h1;
   wire [19:0] lag_t = 20'(lag) * 20'(hdiv) - 20'h1;
   wire [19:0] gap_t = 20'(gap) * 20'(hdiv) * 20'h2 - 20'h1;

   always_comb
   begin
      next_state = state;
      next_tmr = (tmr == 20'h0) ? 20'h0 : tmr - 20'h1;
      next_ecnt = ecnt;
      next_sck = SCK_O;
      next_ss = SS_O;
      do_load = 1'b0;
      do_drive = 1'b0;
      do_sample = 1'b0;
      unit_end = 1'b0;
      fin_set = 1'b0;
      load_drive = ~cpha | ~mst;
      if (!(en && mst))
      begin
         next_state = ST_IDLE;
         next_ss = 1'b1;
         next_sck = cpol;
         if (s_on && !cpha)
         begin
            do_load = ss_fall | (trail_e & ~sl_busy);
            do_sample = lead_e;
            do_drive = trail_e & sl_busy;
         end
         else if (s_on)
         begin
            do_load = lead_e & ~sl_busy;
            do_drive = lead_e & sl_busy;
            do_sample = trail_e;
         end
         if (do_sample && bcnt == last_bit)
         begin
            unit_end = 1'b1;
            fin_set = tx_empty;
         end
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               next_sck = cpol;
               if (!tx_empty)
               begin
                  next_ss = 1'b0;
                  next_state = ST_LEAD;
                  next_tmr = lead_t;
               end
            end
            ST_LEAD:
               if (tmr == 20'h0)
               begin
                  do_load = 1'b1;
                  next_state = ST_XFER;
                  next_tmr = half_t;
                  next_ecnt = 5'h00;
               end
            ST_XFER:
               if (tmr == 20'h0)
               begin
                  next_sck = ~SCK_O;
                  next_tmr = half_t;
                  next_ecnt = ecnt + 5'h01;
                  do_sample = (~ecnt[0]) == ~cpha;
                  do_drive = (~ecnt[0]) == cpha;
                  if (ecnt == last_edge)
                  begin
                     unit_end = 1'b1;
                     if (gap == 8'h00 && !tx_empty)
                     begin
                        do_load = 1'b1;
                        next_ecnt = 5'h00;
                     end
                     else
                     begin
                        fin_set = tx_empty;
                        next_state = ST_LAG;
                        next_tmr = lag_t;
                     end
                  end
               end
            ST_LAG:
               if (tmr == 20'h0)
               begin
                  next_ss = 1'b1;
                  next_state = (gap == 8'h00) ? ST_IDLE : ST_GAP;
                  next_tmr = gap_t;
               end
            ST_GAP:
               if (tmr == 20'h0)
                  next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         state <= ST_IDLE;
         tmr <= 20'h0;
         ecnt <= 5'h00;
         SCK_O <= 1'b0;
         SS_O <= 1'b1;
         SCK_OE <= 1'b0;
         SS_OE <= 1'b0;
         SOUT_OE <= 1'b0;
         sck_prev <= 1'b0;
         ss_prev <= 1'b1;
         push_pend <= 1'b0;
      end
      else
      begin
         state <= next_state;
         tmr <= next_tmr;
         ecnt <= next_ecnt;
         SCK_O <= next_sck;
         SS_O <= next_ss;
         SCK_OE <= en & mst;
         SS_OE <= en & mst;
         SOUT_OE <= en & (mst | ~SS_I);
         sck_prev <= SCK_I;
         ss_prev <= SS_I;
         push_pend <= unit_end;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shift registers. Bit order and size must match the far end.

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         tx_sh <= 16'h0000;
         rx_sh <= 16'h0000;
         SOUT_O <= 1'b1;
         bcnt <= 5'h00;
         sl_busy <= 1'b0;
      end
      else
      begin
         if (do_load && load_drive)
         begin
            SOUT_O <= lsb ? load_val[0] : (wsz ? load_val[15] : load_val[7]);
            tx_sh <= lsb ? {1'b0, load_val[15:1]} : {load_val[14:0], 1'b0};
         end
         else if (do_load)
            tx_sh <= load_val;
         else if (do_drive)
         begin
            SOUT_O <= lsb ? tx_sh[0] : (wsz ? tx_sh[15] : tx_sh[7]);
            tx_sh <= lsb ? {1'b0, tx_sh[15:1]} : {tx_sh[14:0], 1'b0};
         end
         if (do_sample)
            rx_sh <= lsb ? {SIN_I, rx_sh[15:1]} : {rx_sh[14:0], SIN_I};
         if (do_load || unit_end)
            bcnt <= 5'h00;
         else if (do_sample)
            bcnt <= bcnt + 5'h01;
         if (!s_act || unit_end)
            sl_busy <= 1'b0;
         else if (do_load)
            sl_busy <= 1'b1;
      end
   end

endmodule

/* hw/sfp_pkg.sv */
// Constants, register map and state encoding of the FIFO serial port.
// Notes on behaviour
// - Writing 1 to clear bit 0 clears the transmit threshold request.
// - Writing 1 to clear bit 1 clears the receive threshold request.
// - Writing 1 to clear bit 2 clears the transfer-done request.
// - Writing 1 to clear bit 3 clears the overrun flag and request.
// - Writing 1 to clear bit 4 clears the mode fault flag and request.
// - Writing 1 to clear bit 5 clears the per-unit done flag.
// - Writing 1 to clear bit 8 clears the write overflow flag.
// - Writing 1 to bit 15 re-issues the request while a source is pending.
// - Transmit fill count reported in bits 2 to 0, zero after reset.
// - Receive fill count reported in bits 10 to 8, zero after reset.
// - One master-select bit chooses master or slave role.
// - Divider, lead, lag and gap shape clock and select only as master.
// - Both link ends use the same polarity, phase, order and size.
// - As master a transfer starts once transmit data is written.
// - As slave with phase 0 a transfer starts at select falling edge.
// - Phase 0 samples on leading clock edge, shifts on trailing edge.
// - As slave with phase 1 a transfer starts at first clock edge.
// - Phase 1 shifts on leading clock edge, samples on trailing edge.
// - Four-entry transmit and receive FIFOs hold bytes or words alike.
// - A unit arriving at a full receive FIFO is dropped, overrun set.
// - A transmit write into a full FIFO sets write overflow, no request.
package sfp_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [15:0] IDX_CTRL = 16'hF780;
   localparam logic [15:0] IDX_TIMING = 16'hF784;
   localparam logic [15:0] IDX_STATUS = 16'hF788;
   localparam logic [15:0] IDX_FLAG_CLEAR = 16'hF78A;
   localparam logic [15:0] IDX_FILL = 16'hF78C;
   localparam logic [15:0] IDX_TX_DATA = 16'hF78E;
   localparam logic [15:0] IDX_RX_DATA = 16'hF790;
   // Control fields.
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_MASTER = 1;
   localparam int CTRL_CPOL = 2;
   localparam int CTRL_CPHA = 3;
   localparam int CTRL_LSB_FIRST = 4;
   localparam int CTRL_WORD = 5;
   localparam int CTRL_FIFO_CLEAR = 6;
   localparam int CTRL_TX_THR_LSB = 8;
   localparam int CTRL_RX_THR_LSB = 12;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Timing fields: divider 9:0, lead 13:12, lag 15:14, gap 23:16.
   localparam int TIM_DIV_LSB = 0;
   localparam int TIM_LEAD_LSB = 12;
   localparam int TIM_LAG_LSB = 14;
   localparam int TIM_GAP_LSB = 16;
   localparam logic [31:0] TIMING_RESET = 32'h0000_5002;
   // Status and clear bit positions.
   localparam int FLG_TX_THR = 0;
   localparam int FLG_RX_THR = 1;
   localparam int FLG_DONE = 2;
   localparam int FLG_OVERRUN = 3;
   localparam int FLG_MODE_FAULT = 4;
   localparam int FLG_UNIT_DONE = 5;
   localparam int FLG_WRITE_OVF = 8;
   localparam int FLG_TX_FULL = 9;
   localparam int FLG_TX_EMPTY = 10;
   localparam int FLG_RX_FULL = 11;
   localparam int FLG_RX_EMPTY = 12;
   localparam int CLR_REREQUEST = 15;
   localparam int FILL_TX_LSB = 0;
   localparam int FILL_RX_LSB = 8;
   localparam int FIFO_DEPTH = 4;
   localparam logic [15:0] IDLE_FILL = 16'hFFFF;
   localparam logic [4:0] LAST_EDGE_BYTE = 5'h0F;
   localparam logic [4:0] LAST_EDGE_WORD = 5'h1F;
   localparam logic [4:0] LAST_BIT_BYTE = 5'h07;
   localparam logic [4:0] LAST_BIT_WORD = 5'h0F;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_LEAD = 5'h02,
      ST_XFER = 5'h04,
      ST_LAG = 5'h08,
      ST_GAP = 5'h10
   } sfp_state_t;

   // Lead and lag codes in half serial clock periods: 1, 1, 2, 3.
   function automatic logic [1:0] sfp_halves(input logic [1:0] code);
      sfp_halves = (code == 2'h0) ? 2'h1 : code;
   endfunction
endpackage

/* verification/sfp_top_asserts.sv */
// Port-level assertions of the FIFO serial port.
`timescale 1ns/1ps
module sfp_top_asserts
   import sfp_pkg::*;
#(
   parameter int ADDR_W = 18
)
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic RSTN,
   // APB.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   // Serial link.
   input wire logic SCK_O,
   input wire logic SCK_OE,
   input wire logic SS_I,
   input wire logic SS_O,
   input wire logic SS_OE
);
   localparam logic [ADDR_W-1:0] A_CLR = ADDR_W'({IDX_FLAG_CLEAR, 2'b00});
   localparam logic [ADDR_W-1:0] A_FILL = ADDR_W'({IDX_FILL, 2'b00});
   localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'({IDX_STATUS, 2'b00});
   localparam logic [ADDR_W-1:0] A_TX = ADDR_W'({IDX_TX_DATA, 2'b00});
   logic rd;
   logic wrote;
   logic [7:0] edges;
   assign rd = PSEL && PENABLE && PREADY && !PWRITE;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   ////////////////
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
         wrote <= 1'b0;
      else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == A_TX)
         wrote <= 1'b1;
   end
   // Edges are counted per select-low stretch, so one frame of several units still adds up.
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
         edges <= 8'h00;
      else if (SS_O)
         edges <= 8'h00;
      else if ($changed(SCK_O))
         edges <= edges + 8'h01;
   end
   ////////////////
   AST_CLR_READ_ZERO: assert property (rd && PADDR == A_CLR |-> PRDATA == 32'h0)
      else $error("flag clear register read back non-zero");
   AST_FILL_CODES: assert property (rd && PADDR == A_FILL |->
      PRDATA[2:0] <= 3'h4 && PRDATA[10:8] <= 3'h4)
      else $error("fill count code above four");
   AST_STATUS_CONSIST: assert property (rd && PADDR == A_STAT |->
      !(PRDATA[9] && PRDATA[10]) && !(PRDATA[11] && PRDATA[12]))
      else $error("fifo full and empty at once");
   AST_NO_START_EARLY: assert property (!wrote |-> SS_O)
      else $error("frame began before any transmit write");
   AST_LEAD_GAP: assert property ($fell(SS_O) && SS_OE |=> $stable(SCK_O))
      else $error("clock moved with no lead after select");
   AST_SELECT_CLOCKED: assert property (SS_OE && !SS_O |-> SCK_OE)
      else $error("slave selected without driven clock");
   AST_UNIT_EDGES: assert property ($rose(SS_O) && SS_OE |->
      edges != 8'h00 && edges[3:0] == 4'h0)
      else $error("frame edge count not whole units");
   AST_FAULT_RELEASE: assert property (SS_OE && SS_O && !SS_I |-> ##[1:8] !SCK_OE)
      else $error("master role kept after select fault");
endmodule

/* verification/sfp_link_slave.sv */
// Behavioural serial slave facing the port's master frames.
`timescale 1ns/1ps
module sfp_link_slave
(
   // Link wires.
   input wire logic sck,
   input wire logic ss_n,
   input wire logic mosi,
   output logic miso,
   // Frame format, set alike at both ends.
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsb,
   input wire logic word
);
   logic [15:0] tq[$];
   logic [15:0] rq[$];
   logic [15:0] sh = 16'hFFFF;
   logic [15:0] rx = 16'h0000;
   logic last = 1'b1;
   logic pend = 1'b0;
   logic cur;
   int ns = 0;
   int p = 0;
   function automatic int pos(input int i, input logic l, input logic w);
      pos = l ? i : (w ? 15 : 7) - i;
   endfunction
   ////////////////
   // A unit loaded ahead at the end of a phase-0 unit is kept for the next frame.
   always @(negedge ss_n)
   begin
      ns = 0;
      p = cpha ? -1 : 0;
      if (!pend)
         sh = (tq.size() != 0) ? tq.pop_front() : 16'hFFFF;
      pend = 1'b0;
   end
   always @(sck)
   begin
      if (!ss_n)
      begin
         if ((sck != cpol) != cpha)
         begin
            rx[pos(ns, lsb, word)] = mosi;
            ns++;
            if (ns == (word ? 16 : 8))
            begin
               rq.push_back(rx);
               ns = 0;
            end
         end
         else
         begin
            p++;
            if (p == (word ? 16 : 8))
            begin
               p = 0;
               pend = !cpha && tq.size() != 0;
               sh = (tq.size() != 0) ? tq.pop_front() : 16'hFFFF;
            end
         end
      end
   end
   always @*
   begin
      cur = sh[pos((p < 0) ? 0 : p, lsb, word)];
   end
   always @(ss_n or cur)
   begin
      if (!ss_n)
         last = cur;
   end
   // A released data line shows the inverse of its last level.
   assign miso = ss_n ? ~last : cur;
endmodule

/* verification/tb_top.sv */
// Self-checking bench of the FIFO serial port.
`timescale 1ns/1ps
module tb_top;
   import sfp_pkg::*;
   localparam int ADDR_W = 18;
   localparam int LIMIT = 20000;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, last_err;
   logic sck_o, sck_oe, ss_o, ss_oe, sout_o, sout_oe, irq, miso;
   logic ss_fault = 1'b0, sck_drv = 1'b0;
   logic cpol = 1'b0, cpha = 1'b0, lsb = 1'b0, word = 1'b0;
   int num_errors = 0, checks = 0, cycles = 0, irq_cnt = 0;
   wire ss_wire = ss_fault ? 1'b0 : (ss_oe ? ss_o : 1'b1);
   wire sck_wire = sck_oe ? sck_o : sck_drv;
   wire mosi = sout_oe ? sout_o : ~sout_o;
   sfp_top #(.ADDR_W(ADDR_W)) dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .SCK_I(sck_wire), .SCK_O(sck_o), .SCK_OE(sck_oe),
      .SS_I(ss_wire), .SS_O(ss_o), .SS_OE(ss_oe), .SIN_I(miso), .SOUT_O(sout_o),
      .SOUT_OE(sout_oe), .IRQ(irq));
   sfp_link_slave peer (.sck(sck_wire), .ss_n(ss_wire), .mosi(mosi), .miso(miso),
      .cpol(cpol), .cpha(cpha), .lsb(lsb), .word(word));
   initial forever #2.5 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (irq === 1'b1)
         irq_cnt++;
      if (cycles == LIMIT)
      begin
         num_errors++;
         results();
      end
   end
   ////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      apb(1'b1, idx, wd, d);
   endtask
   task automatic rdc(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      apb(1'b0, idx, 32'h0, d);
      chk(d & m, e & m);
   endtask
   task automatic wait_rx(input logic [2:0] n);
      logic [31:0] d;
      d = 32'h0;
      while (d[10:8] !== n) apb(1'b0, IDX_FILL, 32'h0, d);
      while (ss_o !== 1'b1) @(posedge clk);
   endtask
   function automatic logic [31:0] ctl(logic en, logic [2:0] tt, logic [2:0] rt, logic [3:0] f);
      ctl = {16'h0000, 1'b0, rt, 1'b0, tt, 2'b00, f, en, en};
   endfunction
   ////////////////
   initial
   begin
      logic [31:0] d, m, e;
      logic [3:0] f;
      logic [15:0] v;
      logic [15:0] exp_rx[$];
      logic [15:0] exp_tx[$];
      int c;
      static int fb[5] = '{0, 1, 2, 3, 5};
      void'($urandom(32'h19B6E143));
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rdc(IDX_STATUS, 32'h1F3F, 32'h1400);
      rdc(IDX_FILL, 32'h0707, 32'h0);
      rdc(IDX_FLAG_CLEAR, 32'hFFFFFFFF, 32'h0);
      apb(1'b0, 16'hF7A0, 32'h0, d);
      chk({d[30:0], last_err}, 32'h1);
      $display("test reset values done");
      for (int i = 0; i < 8; i++)
      begin
         f = {i[0] ^ i[1], i[2], i[1], i[0]};
         {word, lsb, cpha, cpol} <= f;
         m = f[3] ? 32'hFFFF : 32'hFF;
         wr(IDX_CTRL, ctl(1'b1, 3'h0, 3'h0, f));
         v = 16'($urandom());
         peer.tq.push_back(v);
         d = $urandom() & m;
         wr(IDX_TX_DATA, d);
         wait_rx(3'h1);
         rdc(IDX_RX_DATA, m, {16'h0, v});
         chk({16'h0, peer.rq.pop_front()} & m, d);
         rdc(IDX_STATUS, 32'h20, 32'h20);
         wr(IDX_FLAG_CLEAR, 32'h20);
         rdc(IDX_STATUS, 32'h20, 32'h0);
      end
      $display("test clock modes done");
      {word, lsb, cpha, cpol} <= 4'h0;
      wr(IDX_CTRL, ctl(1'b0, 3'h0, 3'h0, 4'h0));
      c = irq_cnt;
      for (int i = 0; i < 5; i++)
      begin
         v = 16'($urandom()) & 16'hFF;
         if (i < 4)
            exp_tx.push_back(v);
         wr(IDX_TX_DATA, {16'h0, v});
      end
      rdc(IDX_FILL, 32'h0707, 32'h4);
      chk(irq_cnt, c);
      wr(IDX_FLAG_CLEAR, 32'h0);
      rdc(IDX_STATUS, 32'h0300, 32'h0300);
      wr(IDX_FLAG_CLEAR, 32'h0100);
      rdc(IDX_STATUS, 32'h0100, 32'h0);
      $display("test write overflow done");
      for (int i = 0; i < 5; i++)
      begin
         v = 16'($urandom());
         peer.tq.push_back(v);
         if (i < 4)
            exp_rx.push_back(v & 16'hFF);
      end
      c = irq_cnt;
      wr(IDX_CTRL, ctl(1'b1, 3'h3, 3'h1, 4'h0));
      wait_rx(3'h4);
      exp_tx.push_back(16'h5A);
      wr(IDX_TX_DATA, 32'h5A);
      do apb(1'b0, IDX_STATUS, 32'h0, d); while (d[3] !== 1'b1);
      while (ss_o !== 1'b1) @(posedge clk);
      rdc(IDX_FILL, 32'h0707, 32'h0400);
      chk(irq_cnt > c, 32'h1);
      e = 32'h2F;
      rdc(IDX_STATUS, 32'h3F, e);
      c = irq_cnt;
      wr(IDX_FLAG_CLEAR, 32'h8000);
      repeat (4) @(posedge clk);
      chk(irq_cnt - c, 32'h1);
      foreach (fb[k])
      begin
         e = e & ~(32'h1 << fb[k]);
         wr(IDX_FLAG_CLEAR, 32'h1 << fb[k]);
         rdc(IDX_STATUS, 32'h3F, e);
      end
      for (int i = 0; i < 4; i++)
         rdc(IDX_RX_DATA, 32'hFF, {16'h0, exp_rx.pop_front()});
      rdc(IDX_FILL, 32'h0707, 32'h0);
      for (int i = 0; i < 5; i++)
         chk({16'h0, peer.rq.pop_front()} & 32'hFF, {16'h0, exp_tx.pop_front()});
      $display("test overrun and clears done");
      ss_fault <= 1'b1;
      while (sck_oe !== 1'b0) @(posedge clk);
      ss_fault <= 1'b0;
      rdc(IDX_STATUS, 32'h10, 32'h10);
      wr(IDX_FLAG_CLEAR, 32'h10);
      rdc(IDX_STATUS, 32'h3F, 32'h0);
      c = irq_cnt;
      wr(IDX_FLAG_CLEAR, 32'h8000);
      repeat (4) @(posedge clk);
      chk(irq_cnt - c, 32'h0);
      $display("test mode fault done");
      v = 16'($urandom());
      peer.tq.push_back(v);
      wr(IDX_CTRL, 32'h1);
      wr(IDX_TX_DATA, 32'hA5);
      ss_fault <= 1'b1;
      repeat (16)
      begin
         repeat (8) @(posedge clk);
         sck_drv <= ~sck_drv;
      end
      repeat (8) @(posedge clk);
      ss_fault <= 1'b0;
      rdc(IDX_RX_DATA, 32'hFF, {16'h0, v});
      chk({16'h0, peer.rq.pop_front()} & 32'hFF, 32'hA5);
      $display("test slave done");
      results();
   end
endmodule
bind sfp_top sfp_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .SCK_O(SCK_O), .SCK_OE(SCK_OE), .SS_I(SS_I), .SS_O(SS_O), .SS_OE(SS_OE));
